// ==== verilog/cagss_pkg.sv ====
// Shared constants and types of the address, status and stack core.
// Assumes a single clock domain and a synchronous active-high reset.
`default_nettype none

package cagss_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int CAGSS_PC_W = 10;          // Program counter width
  localparam int CAGSS_DISP_W = 6;         // Displacement field width
  localparam int CAGSS_K_W = 12;           // Relative offset width
  localparam int CAGSS_NREG = 32;          // Working registers
  localparam int CAGSS_CLK_PERIOD_NS = 5;  // System clock period
  localparam int CAGSS_SRAM_CYCLES = 2;    // Cycles per data access

  // ----------------------------------------------------------------
  // Register offsets in the I/O space and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] CAGSS_SP_ADDR = 6'h3D;
  localparam logic [5:0] CAGSS_STATUS_FLAGS_ADDR = 6'h3F;
  localparam logic [5:0] CAGSS_IO_BIT_LAST = 6'h1F;  // Last bit-addressable location
  localparam logic [7:0] CAGSS_SP_RESET = 8'h00;
  localparam logic [7:0] CAGSS_STATUS_FLAGS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam int CAGSS_FLAG_C = 0;
  localparam int CAGSS_FLAG_Z = 1;
  localparam int CAGSS_FLAG_N = 2;
  localparam int CAGSS_FLAG_V = 3;
  localparam int CAGSS_FLAG_S = 4;
  localparam int CAGSS_FLAG_H = 5;
  localparam int CAGSS_FLAG_T = 6;
  localparam int CAGSS_FLAG_I = 7;

  // ----------------------------------------------------------------
  // Pointer pairs (low byte register index)
  // ----------------------------------------------------------------
  localparam logic [4:0] CAGSS_X_LO = 5'h1A;
  localparam logic [4:0] CAGSS_Y_LO = 5'h1C;
  localparam logic [4:0] CAGSS_Z_LO = 5'h1E;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_ALU_ADD, OP_ALU_ADC, OP_ALU_SUB, OP_ALU_SBC, OP_ALU_AND,
    OP_ALU_OR, OP_ALU_XOR, OP_MOVE, OP_LOAD_IMM, OP_DATA_LOAD, OP_DATA_STORE,
    OP_PROG_CONST_LOAD, OP_JUMP_VIA_Z, OP_CALL_VIA_Z, OP_REL_JUMP, OP_REL_CALL,
    OP_SUB_EXIT, OP_IRQ_EXIT, OP_PUSH, OP_POP, OP_GATE_SET, OP_GATE_CLEAR,
    OP_BIT_STORE, OP_BIT_LOAD, OP_IO_IN, OP_IO_OUT, OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR, OP_SKIP_IO_ONE, OP_SKIP_IO_ZERO
  } cagss_op_e;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} cagss_ptr_e;

  typedef enum logic [1:0] {AM_PLAIN, AM_PREDEC, AM_POSTINC, AM_DISP} cagss_amode_e;

  typedef enum logic [1:0] {ST_EXEC = 2'b00, ST_ACC1 = 2'b01, ST_ACC2 = 2'b11} cagss_state_e;

  typedef enum logic [3:0] {
    K_LOAD, K_STORE, K_PROG, K_IO_RD, K_IO_SKIP, K_PUSH_LO, K_PUSH_HI, K_POP_HI, K_POP_LO
  } cagss_kind_e;

endpackage

`default_nettype wire

// ==== verilog/cagss_core.sv ====
// Address generation, status flags and stack pointer of an 8-bit core.
// Assumes decoded instructions arrive on a valid/ready port and that data
// SRAM, program memory and peripheral I/O answer one cycle after a request.
`timescale 1ns/1ps
`default_nettype none

module cagss_core import cagss_pkg::*; #(
  parameter int PC_W = CAGSS_PC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction stream
  input wire logic instr_valid,
  input wire cagss_op_e instr_op,
  input wire logic [4:0] instr_rd,
  input wire logic [4:0] instr_rr,
  input wire logic [7:0] instr_imm,
  input wire cagss_ptr_e instr_ptr,
  input wire cagss_amode_e instr_mode,
  input wire logic [CAGSS_DISP_W-1:0] instr_disp,
  input wire logic [CAGSS_K_W-1:0] instr_k,
  input wire logic [5:0] instr_io,
  input wire logic [2:0] instr_bit,
  output logic instr_ready_r,
  output logic [PC_W-1:0] pc_r,
  // Interrupt request from the vector logic
  input wire logic irq_req,
  input wire logic [PC_W-1:0] irq_vector,
  output logic irq_taken_r,
  // Data memory
  output logic data_req_r,
  output logic data_we_r,
  output logic [15:0] data_addr_r,
  output logic [7:0] data_wdata_r,
  input wire logic [7:0] data_rdata,
  // Program memory constant port
  output logic prog_req_r,
  output logic [PC_W-1:0] prog_addr_r,
  input wire logic [15:0] prog_rdata,
  // Peripheral I/O space
  output logic io_rd_r,
  output logic io_we_r,
  output logic io_bset_r,
  output logic io_bclr_r,
  output logic [5:0] io_addr_r,
  output logic [2:0] io_bit_r,
  output logic [7:0] io_wdata_r,
  input wire logic [7:0] io_rdata,
  // Visible state
  output logic [7:0] status_flags_r,
  output logic [7:0] stack_pointer_r,
  output logic wb_we_r,
  output logic [4:0] wb_idx_r,
  output logic [7:0] wb_data_r
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (PC_W < 1 || PC_W > 15) begin : g_bad_pc_w
    $error("PC_W must lie between 1 and 15");
  end

  // Pointer pair low register for a selector
  function automatic logic [4:0] ptr_index(input cagss_ptr_e sel);
    unique case (sel)
      PTR_X: ptr_index = CAGSS_X_LO;
      PTR_Y: ptr_index = CAGSS_Y_LO;
      default: ptr_index = CAGSS_Z_LO;
    endcase
  endfunction

  // Sign flag is derived, never stored independently
  function automatic logic [7:0] sign_fix(input logic [7:0] s);
    sign_fix = s;
    sign_fix[CAGSS_FLAG_S] = s[CAGSS_FLAG_N] ^ s[CAGSS_FLAG_V];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] rf [CAGSS_NREG];
  cagss_state_e state_r, state_nxt;
  cagss_kind_e kind_r, kind_nxt;
  logic [4:0] dest_r, dest_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic pol_r, pol_nxt;
  logic byte_hi_r, byte_hi_nxt;
  logic [15:0] ret_r, ret_nxt;
  logic [7:0] stk_r, stk_nxt;
  logic irq_pend_r, irq_pend_nxt;
  logic [7:0] sp_nxt, status_flags_pre, status_flags_nxt;
  logic [PC_W-1:0] pc_nxt;
  logic rf_we, ptr_we, taken;
  logic [4:0] rf_idx, ptr_idx;
  logic [7:0] rf_wdata;
  logic [15:0] ptr_val, ptr_wdata, zval, ret16;
  logic d_req, d_we, p_req, io_rd, io_we, io_set, io_clr;
  logic [15:0] d_addr;
  logic [7:0] d_wdata, io_wdata;
  logic [PC_W-1:0] p_addr;
  logic [5:0] io_addr;
  logic [2:0] io_bit;
  logic accept, take_irq;
  logic [7:0] a, b, r;
  logic cin, sub_op;
  logic [8:0] sum;

  // ----------------------------------------------------------------
  // Operand and pointer views
  // ----------------------------------------------------------------
  assign ptr_idx = ptr_index(instr_ptr);
  assign ptr_val = {rf[ptr_idx + 5'h01], rf[ptr_idx]};
  assign zval = {rf[CAGSS_Z_LO + 5'h01], rf[CAGSS_Z_LO]};
  assign ret16 = 16'(pc_r + PC_W'(1));
  // Interrupt entry only between instructions, so no instruction is half done
  assign take_irq = (state_r == ST_EXEC) && irq_pend_r;
  assign accept = (state_r == ST_EXEC) && instr_ready_r && instr_valid;
  assign a = rf[instr_rd];
  assign b = rf[instr_rr];
  assign sub_op = (instr_op == OP_ALU_SUB) || (instr_op == OP_ALU_SBC);
  assign cin = ((instr_op == OP_ALU_ADC) || (instr_op == OP_ALU_SBC)) && status_flags_r[CAGSS_FLAG_C];
  assign sum = sub_op ? ({1'b0, a} - {1'b0, b} - {8'h00, cin}) : ({1'b0, a} + {1'b0, b} + {8'h00, cin});

  // ----------------------------------------------------------------
  // Execute and memory sequencing
  // ----------------------------------------------------------------
  // One decision per cycle; every side effect leaves through a register
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    dest_nxt = dest_r;
    sel_nxt = sel_r;
    pol_nxt = pol_r;
    byte_hi_nxt = byte_hi_r;
    ret_nxt = ret_r;
    stk_nxt = stk_r;
    sp_nxt = stack_pointer_r;
    status_flags_pre = status_flags_r;
    pc_nxt = pc_r;
    rf_we = 1'b0;
    rf_idx = instr_rd;
    rf_wdata = 8'h00;
    ptr_we = 1'b0;
    ptr_wdata = ptr_val;
    d_req = 1'b0;
    d_we = 1'b0;
    d_addr = data_addr_r;
    d_wdata = data_wdata_r;
    p_req = 1'b0;
    p_addr = prog_addr_r;
    io_rd = 1'b0;
    io_we = 1'b0;
    io_set = 1'b0;
    io_clr = 1'b0;
    io_addr = io_addr_r;
    io_bit = io_bit_r;
    io_wdata = io_wdata_r;
    taken = 1'b0;
    r = sum[7:0];
    unique case (state_r)
      ST_EXEC: begin
        if (take_irq) begin
          taken = 1'b1;
          status_flags_pre[CAGSS_FLAG_I] = 1'b0;
          d_req = 1'b1;
          d_we = 1'b1;
          d_addr = {8'h00, stack_pointer_r};
          d_wdata = 8'(pc_r);
          ret_nxt = 16'(pc_r);
          stk_nxt = stack_pointer_r - 8'h01;
          sp_nxt = stack_pointer_r - 8'h02;
          pc_nxt = irq_vector;
          kind_nxt = K_PUSH_LO;
          state_nxt = ST_ACC1;
        end else if (accept) begin
          pc_nxt = pc_r + PC_W'(1);
          unique case (instr_op)
            OP_ALU_ADD, OP_ALU_ADC, OP_ALU_SUB, OP_ALU_SBC, OP_ALU_AND, OP_ALU_OR, OP_ALU_XOR: begin
              if (instr_op == OP_ALU_AND) r = a & b;
              else if (instr_op == OP_ALU_OR) r = a | b;
              else if (instr_op == OP_ALU_XOR) r = a ^ b;
              rf_we = 1'b1;
              rf_wdata = r;
              status_flags_pre[CAGSS_FLAG_N] = r[7];
              status_flags_pre[CAGSS_FLAG_Z] = (r == 8'h00) &&
                ((instr_op != OP_ALU_SBC) || status_flags_r[CAGSS_FLAG_Z]);
              if (instr_op == OP_ALU_AND || instr_op == OP_ALU_OR || instr_op == OP_ALU_XOR) begin
                status_flags_pre[CAGSS_FLAG_V] = 1'b0;
              end else if (sub_op) begin
                status_flags_pre[CAGSS_FLAG_C] = sum[8];
                status_flags_pre[CAGSS_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
                status_flags_pre[CAGSS_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
              end else begin
                status_flags_pre[CAGSS_FLAG_C] = sum[8];
                status_flags_pre[CAGSS_FLAG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
                status_flags_pre[CAGSS_FLAG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
              end
            end
            OP_MOVE: begin
              rf_we = 1'b1;
              rf_wdata = b;
            end
            OP_LOAD_IMM: begin
              rf_we = 1'b1;
              rf_wdata = instr_imm;
            end
            OP_DATA_LOAD, OP_DATA_STORE: begin
              d_req = 1'b1;
              d_we = (instr_op == OP_DATA_STORE);
              d_wdata = a;
              dest_nxt = instr_rd;
              kind_nxt = (instr_op == OP_DATA_STORE) ? K_STORE : K_LOAD;
              state_nxt = ST_ACC1;
              unique case (instr_mode)
                AM_PLAIN: d_addr = ptr_val;
                AM_PREDEC: begin
                  ptr_we = 1'b1;
                  ptr_wdata = ptr_val - 16'h0001;
                  d_addr = ptr_val - 16'h0001;
                end
                AM_POSTINC: begin
                  ptr_we = 1'b1;
                  ptr_wdata = ptr_val + 16'h0001;
                  d_addr = ptr_val;
                end
                AM_DISP: d_addr = ptr_val + {10'h000, instr_disp};
              endcase
            end
            OP_PROG_CONST_LOAD: begin
              p_req = 1'b1;
              p_addr = PC_W'(zval[15:1]);
              byte_hi_nxt = zval[0];
              dest_nxt = instr_rd;
              kind_nxt = K_PROG;
              state_nxt = ST_ACC1;
            end
            OP_JUMP_VIA_Z: pc_nxt = PC_W'(zval);
            OP_REL_JUMP: pc_nxt = PC_W'(16'(pc_r) + {{4{instr_k[11]}}, instr_k} + 16'h0001);
            OP_CALL_VIA_Z, OP_REL_CALL: begin
              if (instr_op == OP_CALL_VIA_Z) pc_nxt = PC_W'(zval);
              else pc_nxt = PC_W'(16'(pc_r) + {{4{instr_k[11]}}, instr_k} + 16'h0001);
              d_req = 1'b1;
              d_we = 1'b1;
              d_addr = {8'h00, stack_pointer_r};
              d_wdata = ret16[7:0];
              ret_nxt = ret16;
              stk_nxt = stack_pointer_r - 8'h01;
              sp_nxt = stack_pointer_r - 8'h02;
              kind_nxt = K_PUSH_LO;
              state_nxt = ST_ACC1;
            end
            OP_SUB_EXIT, OP_IRQ_EXIT: begin
              if (instr_op == OP_IRQ_EXIT) status_flags_pre[CAGSS_FLAG_I] = 1'b1;
              d_req = 1'b1;
              d_addr = {8'h00, stack_pointer_r + 8'h01};
              stk_nxt = stack_pointer_r + 8'h02;
              sp_nxt = stack_pointer_r + 8'h02;
              kind_nxt = K_POP_HI;
              state_nxt = ST_ACC1;
            end
            OP_PUSH: begin
              d_req = 1'b1;
              d_we = 1'b1;
              d_addr = {8'h00, stack_pointer_r};
              d_wdata = a;
              sp_nxt = stack_pointer_r - 8'h01;
              kind_nxt = K_STORE;
              state_nxt = ST_ACC1;
            end
            OP_POP: begin
              d_req = 1'b1;
              d_addr = {8'h00, stack_pointer_r + 8'h01};
              sp_nxt = stack_pointer_r + 8'h01;
              dest_nxt = instr_rd;
              kind_nxt = K_LOAD;
              state_nxt = ST_ACC1;
            end
            OP_GATE_SET: status_flags_pre[CAGSS_FLAG_I] = 1'b1;
            OP_GATE_CLEAR: status_flags_pre[CAGSS_FLAG_I] = 1'b0;
            OP_BIT_STORE: status_flags_pre[CAGSS_FLAG_T] = a[instr_bit];
            OP_BIT_LOAD: begin
              rf_we = 1'b1;
              rf_wdata = a;
              rf_wdata[instr_bit] = status_flags_r[CAGSS_FLAG_T];
            end
            OP_IO_IN: begin
              // Core-owned registers answer at once, the rest go out on the port
              if (instr_io == CAGSS_SP_ADDR || instr_io == CAGSS_STATUS_FLAGS_ADDR) begin
                rf_we = 1'b1;
                rf_wdata = (instr_io == CAGSS_SP_ADDR) ? stack_pointer_r : status_flags_r;
              end else begin
                io_rd = 1'b1;
                io_addr = instr_io;
                dest_nxt = instr_rd;
                kind_nxt = K_IO_RD;
                state_nxt = ST_ACC1;
              end
            end
            OP_IO_OUT: begin
              if (instr_io == CAGSS_SP_ADDR) sp_nxt = a;
              else if (instr_io == CAGSS_STATUS_FLAGS_ADDR) status_flags_pre = a;
              else begin
                io_we = 1'b1;
                io_addr = instr_io;
                io_wdata = a;
              end
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              if (instr_io <= CAGSS_IO_BIT_LAST) begin
                io_set = (instr_op == OP_IO_BIT_SET);
                io_clr = (instr_op == OP_IO_BIT_CLEAR);
                io_addr = instr_io;
                io_bit = instr_bit;
              end
            end
            OP_SKIP_IO_ONE, OP_SKIP_IO_ZERO: begin
              if (instr_io <= CAGSS_IO_BIT_LAST) begin
                io_rd = 1'b1;
                io_addr = instr_io;
                sel_nxt = instr_bit;
                pol_nxt = (instr_op == OP_SKIP_IO_ONE);
                kind_nxt = K_IO_SKIP;
                state_nxt = ST_ACC1;
              end
            end
            default: ;
          endcase
        end
      end
      ST_ACC1: state_nxt = ST_ACC2;
      ST_ACC2: begin
        state_nxt = ST_EXEC;
        unique case (kind_r)
          K_LOAD: begin
            rf_we = 1'b1;
            rf_idx = dest_r;
            rf_wdata = data_rdata;
          end
          K_PROG: begin
            rf_we = 1'b1;
            rf_idx = dest_r;
            rf_wdata = byte_hi_r ? prog_rdata[15:8] : prog_rdata[7:0];
          end
          K_IO_RD: begin
            rf_we = 1'b1;
            rf_idx = dest_r;
            rf_wdata = io_rdata;
          end
          K_IO_SKIP: if (io_rdata[sel_r] == pol_r) pc_nxt = pc_r + PC_W'(1);
          K_PUSH_LO: begin
            d_req = 1'b1;
            d_we = 1'b1;
            d_addr = {8'h00, stk_r};
            d_wdata = ret_r[15:8];
            kind_nxt = K_PUSH_HI;
            state_nxt = ST_ACC1;
          end
          K_POP_HI: begin
            ret_nxt[15:8] = data_rdata;
            d_req = 1'b1;
            d_addr = {8'h00, stk_r};
            kind_nxt = K_POP_LO;
            state_nxt = ST_ACC1;
          end
          K_POP_LO: pc_nxt = PC_W'({ret_r[15:8], data_rdata});
          default: ;
        endcase
      end
      default: state_nxt = ST_EXEC;
    endcase
    status_flags_nxt = sign_fix(status_flags_pre);
    // Gate low holds every request off; nothing is left pending meanwhile
    irq_pend_nxt = (state_nxt == ST_EXEC) && irq_req && status_flags_nxt[CAGSS_FLAG_I] && !take_irq;
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_EXEC;
      kind_r <= K_LOAD;
      dest_r <= 5'h00;
      sel_r <= 3'h0;
      pol_r <= 1'b0;
      byte_hi_r <= 1'b0;
      ret_r <= 16'h0000;
      stk_r <= 8'h00;
      irq_pend_r <= 1'b0;
      instr_ready_r <= 1'b0;
      pc_r <= '0;
      irq_taken_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      dest_r <= dest_nxt;
      sel_r <= sel_nxt;
      pol_r <= pol_nxt;
      byte_hi_r <= byte_hi_nxt;
      ret_r <= ret_nxt;
      stk_r <= stk_nxt;
      irq_pend_r <= irq_pend_nxt;
      instr_ready_r <= (state_nxt == ST_EXEC) && !irq_pend_nxt;
      pc_r <= pc_nxt;
      irq_taken_r <= taken;
    end
  end

  // Stack pointer and status flags
  always_ff @(posedge clk) begin
    if (srst) begin
      stack_pointer_r <= CAGSS_SP_RESET;
      status_flags_r <= CAGSS_STATUS_FLAGS_RESET;
    end else begin
      stack_pointer_r <= sp_nxt;
      status_flags_r <= status_flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register file; pointer writes land on both bytes together
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < CAGSS_NREG; i++) begin
        rf[i] <= 8'h00;
      end
      wb_we_r <= 1'b0;
      wb_idx_r <= 5'h00;
      wb_data_r <= 8'h00;
    end else begin
      if (ptr_we) begin
        rf[ptr_idx] <= ptr_wdata[7:0];
        rf[ptr_idx + 5'h01] <= ptr_wdata[15:8];
      end
      if (rf_we) rf[rf_idx] <= rf_wdata;
      wb_we_r <= rf_we;
      wb_idx_r <= rf_idx;
      wb_data_r <= rf_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Memory and I/O request registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      data_req_r <= 1'b0;
      data_we_r <= 1'b0;
      data_addr_r <= 16'h0000;
      data_wdata_r <= 8'h00;
      prog_req_r <= 1'b0;
      prog_addr_r <= '0;
      io_rd_r <= 1'b0;
      io_we_r <= 1'b0;
      io_bset_r <= 1'b0;
      io_bclr_r <= 1'b0;
      io_addr_r <= 6'h00;
      io_bit_r <= 3'h0;
      io_wdata_r <= 8'h00;
    end else begin
      data_req_r <= d_req;
      data_we_r <= d_we;
      data_addr_r <= d_addr;
      data_wdata_r <= d_wdata;
      prog_req_r <= p_req;
      prog_addr_r <= p_addr;
      io_rd_r <= io_rd;
      io_we_r <= io_we;
      io_bset_r <= io_set;
      io_bclr_r <= io_clr;
      io_addr_r <= io_addr;
      io_bit_r <= io_bit;
      io_wdata_r <= io_wdata;
    end
  end

endmodule // cagss_core

`default_nettype wire

// ==== verif/cagss_checker.sv ====
// Assertions on the ports of the address, status and stack core.
// Assumes binding into cagss_core with a single clock.
`timescale 1ns/1ps
`default_nettype none
module cagss_checker import cagss_pkg::*; #(
  parameter int PC_W = CAGSS_PC_W
) (
  // Clock, reset, instructions
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire cagss_op_e instr_op,
  input wire logic [CAGSS_K_W-1:0] instr_k,
  input wire logic instr_ready_r,
  // State
  input wire logic [PC_W-1:0] pc_r,
  input wire logic irq_taken_r,
  input wire logic data_req_r,
  input wire logic [7:0] status_flags_r,
  input wire logic [7:0] stack_pointer_r,
  input wire logic wb_we_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // SP at the take edge; ready is low while an op runs
  logic take;
  logic [7:0] sp_t_r;
  assign take = instr_valid && instr_ready_r;
  always_ff @(posedge clk) begin
    if (take) begin
      sp_t_r <= stack_pointer_r;
    end
  end
  sequence take_s(cagss_op_e op);
    take && instr_op == op;
  endsequence
  sign_flag_a: assert property (status_flags_r[4] == (status_flags_r[2] ^ status_flags_r[3]))
    else $error("sign flag wrong");
  sp_reset_a: assert property ($fell(srst) |-> stack_pointer_r == 8'h00 && status_flags_r == 8'h00)
    else $error("reset values wrong");
  push_sp_a: assert property (take_s(OP_PUSH) |=> ##[0:3] stack_pointer_r == sp_t_r - 8'h01)
    else $error("push step wrong");
  call_sp_a: assert property (take_s(OP_REL_CALL) |=> ##[0:5] stack_pointer_r == sp_t_r - 8'h02)
    else $error("call step wrong");
  ret_sp_a: assert property (take_s(OP_SUB_EXIT) |=> ##[0:5] stack_pointer_r == sp_t_r + 8'h02)
    else $error("return step wrong");
  rel_pc_a: assert property (take_s(OP_REL_JUMP) |=> pc_r == PC_W'($past(pc_r) + $past(instr_k) + 1))
    else $error("relative target wrong");
  sram_two_a: assert property (data_req_r |=> !data_req_r && !instr_ready_r)
    else $error("access not two cycles");
  gate_block_a: assert property ($rose(irq_taken_r) |-> $past(status_flags_r[7]) || $past(status_flags_r[7], 2))
    else $error("irq taken with gate closed");
  gate_clear_a: assert property ($rose(irq_taken_r) |-> ##[0:2] !status_flags_r[7])
    else $error("gate not cleared");
  alu_one_a: assert property (take_s(OP_ALU_ADD) |=> wb_we_r)
    else $error("alu write late");
endmodule // cagss_checker
bind cagss_core cagss_checker #(.PC_W(PC_W)) i_cagss_checker (.*);
`default_nettype wire

// ==== verif/tb_top.sv ====
// Directed bench for the address, status and stack core.
// Assumes memories answer with fixed data; checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
module tb_top import cagss_pkg::*; ;
  logic clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, irq_req = 1'b0;
  cagss_op_e instr_op = OP_NOP;
  cagss_ptr_e instr_ptr = PTR_Z;
  cagss_amode_e instr_mode = AM_PLAIN;
  logic [4:0] instr_rd = 5'h00, instr_rr = 5'h00;
  logic [7:0] instr_imm = 8'h00, data_rdata = 8'hA5, io_rdata = 8'h00;
  logic [5:0] instr_disp = 6'h00, instr_io = 6'h00;
  logic [11:0] instr_k = 12'h000;
  logic [2:0] instr_bit = 3'h6;
  logic [9:0] irq_vector = 10'h005;
  logic [15:0] prog_rdata = 16'h1234;
  logic instr_ready_r, irq_taken_r, data_req_r, data_we_r, prog_req_r, io_rd_r, io_we_r, io_bset_r, io_bclr_r, wb_we_r;
  logic [9:0] pc_r, prog_addr_r, pc0;
  logic [15:0] data_addr_r, addr_seen;
  logic [7:0] data_wdata_r, io_wdata_r, status_flags_r, stack_pointer_r, wb_data_r;
  logic [4:0] wb_idx_r;
  logic [12:0] wb_seen;
  logic [8:0] wr_seen;
  logic [9:0] bit_seen;
  logic [14:0] io_seen;
  logic [5:0] io_addr_r;
  logic [2:0] io_bit_r;
  int err_count = 0, n_compared = 0, n_bset = 0, n_irq = 0;
  cagss_core i_cagss_core (.*);
  always #2.5 clk = ~clk;
  // Latch pulses so checks can run after an op settles
  always @(posedge clk) begin
    if (data_req_r) addr_seen <= data_addr_r;
    if (data_req_r) wr_seen <= {data_we_r, data_wdata_r};
    if (prog_req_r) addr_seen <= {6'h00, prog_addr_r};
    if (wb_we_r) wb_seen <= {wb_idx_r, wb_data_r};
    if (io_bset_r) n_bset <= n_bset + 1;
    if (io_bset_r || io_bclr_r) bit_seen <= {io_bclr_r, io_bit_r, io_addr_r};
    if (io_we_r || io_rd_r) io_seen <= {io_rd_r, io_addr_r, io_wdata_r};
    if (irq_taken_r) n_irq <= n_irq + 1;
  end
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Present one op, wait for its take, then let it finish
  task automatic issue(cagss_op_e op, logic [4:0] rd, logic [7:0] imm);
    int i;
    @(posedge clk);
    instr_op <= op;
    instr_rd <= rd;
    instr_imm <= imm;
    instr_valid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (instr_ready_r !== 1'b1 && i < 20);
    if (i >= 20) begin
      err_count++;
      give_verdict();
    end
    instr_valid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk(stack_pointer_r, 16'h0000);
    chk(status_flags_r, 16'h0000);
    issue(OP_LOAD_IMM, 5'h1E, 8'h05);
    issue(OP_LOAD_IMM, 5'h1F, 8'h01);
    issue(OP_LOAD_IMM, 5'h10, 8'hC0);
    instr_io <= CAGSS_SP_ADDR;
    issue(OP_IO_OUT, 5'h10, 8'h00);
    chk(stack_pointer_r, 16'h00C0);
    issue(OP_PUSH, 5'h10, 8'h00);
    chk(stack_pointer_r, 16'h00BF);
    issue(OP_POP, 5'h11, 8'h00);
    chk(stack_pointer_r, 16'h00C0);
    chk(wb_seen, 16'h11A5);
    pc0 = pc_r;
    instr_k <= 12'hFFE;
    issue(OP_REL_CALL, 5'h00, 8'h00);
    chk(pc_r, {6'h00, pc0 - 10'h001});
    chk(stack_pointer_r, 16'h00BE);
    issue(OP_SUB_EXIT, 5'h00, 8'h00);
    chk(stack_pointer_r, 16'h00C0);
    $display("stack test done");
    instr_mode <= AM_DISP;
    instr_disp <= 6'h3F;
    issue(OP_DATA_LOAD, 5'h12, 8'h00);
    chk(addr_seen, 16'h0144);
    instr_mode <= AM_POSTINC;
    issue(OP_DATA_LOAD, 5'h12, 8'h00);
    chk(addr_seen, 16'h0105);
    instr_mode <= AM_PREDEC;
    issue(OP_DATA_LOAD, 5'h12, 8'h00);
    chk(addr_seen, 16'h0105);
    instr_mode <= AM_PLAIN;
    issue(OP_DATA_STORE, 5'h10, 8'h00);
    chk(addr_seen, 16'h0105);
    chk(wr_seen, 16'h01C0);
    issue(OP_PROG_CONST_LOAD, 5'h12, 8'h00);
    chk(addr_seen, 16'h0082);
    chk(wb_seen, 16'h1212);
    issue(OP_JUMP_VIA_Z, 5'h00, 8'h00);
    chk(pc_r, 16'h0105);
    $display("address test done");
    instr_rr <= 5'h11;
    issue(OP_ALU_ADD, 5'h10, 8'h00);
    chk(wb_seen, 16'h1065);
    chk(status_flags_r, 16'h0019);
    irq_req <= 1'b1;
    issue(OP_GATE_SET, 5'h00, 8'h00);
    irq_req <= 1'b0;
    chk(pc_r, 16'h0005);
    chk(status_flags_r, 16'h0019);
    chk(n_irq, 16'h0001);
    issue(OP_IRQ_EXIT, 5'h00, 8'h00);
    chk(status_flags_r, 16'h0099);
    issue(OP_BIT_STORE, 5'h10, 8'h00);
    chk(status_flags_r, 16'h00D9);
    issue(OP_BIT_LOAD, 5'h12, 8'h00);
    chk(wb_seen, 16'h1252);
    instr_io <= 6'h21;
    issue(OP_IO_BIT_SET, 5'h00, 8'h00);
    instr_io <= 6'h1B;
    issue(OP_IO_BIT_SET, 5'h00, 8'h00);
    chk(n_bset, 16'h0001);
    chk(bit_seen, 16'h019B);
    issue(OP_IO_BIT_CLEAR, 5'h00, 8'h00);
    chk(bit_seen, 16'h039B);
    issue(OP_IO_OUT, 5'h10, 8'h00);
    chk(io_seen, 16'h1B65);
    pc0 = pc_r;
    issue(OP_SKIP_IO_ZERO, 5'h00, 8'h00);
    chk(pc_r, {6'h00, pc0 + 10'h002});
    chk(io_seen, 16'h5B65);
    // Second reset in mid-run must bring back the reset values
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(stack_pointer_r, 16'h0000);
    chk(status_flags_r, 16'h0000);
    $display("status test done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
